// [rtl/gamlut_corrector.sv]
// Gamma look-up corrector: three table ports, run control and streamed correction
//
// Function
// [R1] One control port per parallel channel, each holding its correction table.
// [R2] Table read live per sample; writes affect the very next sample.
// [R3] Every register is exactly the sample width wide.
// [R4] Port 0 address 0 bit 0 is run enable; clearing stops at packet start.
// [R5] Port 0 address 1 bit 0 reports run status; other bits zero.
// [R6] Addresses 2 to 2^N+1 hold one table entry per input intensity.
// [R7] Input intensity x is replaced by the entry at address x plus 2.
// [R8] Ports 1 and 2 addresses 0 and 1 are unused, read zero.
// [R9] Software clears run enable before table edits and sets it after; the bench's t_live edits the table while running.
// [R10] Downstream raises ready only when it can take a word.
// [R11] Upstream marks words with valid; device drives its input ready.
// [R12] Status reads 1 while processing, 0 once stopped after run enable cleared.
`timescale 1ns/1ps
`default_nettype none
module gamlut_corrector #(
   parameter int SAMPLE_WIDTH = gamlut_pkg::SAMPLE_WIDTH,
   parameter int CHANNELS = gamlut_pkg::CHANNELS,
   parameter int FIFO_DEPTH = gamlut_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Control ports, one per channel, single-cycle read latency
   input wire logic [CHANNELS-1:0] ctrlRead,
   input wire logic [CHANNELS-1:0] ctrlWrite,
   input wire logic [CHANNELS-1:0][SAMPLE_WIDTH:0] ctrlAddress,
   input wire logic [CHANNELS-1:0][SAMPLE_WIDTH-1:0] ctrlWriteData,
   output logic [CHANNELS-1:0][SAMPLE_WIDTH-1:0] ctrlReadData,
   output logic [CHANNELS-1:0] ctrlReadDataValid,
   // Input stream
   input wire logic dinValid,
   output logic dinReady,
   input wire logic [CHANNELS*SAMPLE_WIDTH-1:0] dinData,
   input wire logic dinStartOfPacket,
   input wire logic dinEndOfPacket,
   // Output stream
   output logic doutValid,
   input wire logic doutReady,
   output logic [CHANNELS*SAMPLE_WIDTH-1:0] doutData,
   output logic doutStartOfPacket,
   output logic doutEndOfPacket
);
   localparam int ENTRIES = 2 ** SAMPLE_WIDTH;
   localparam int BW = CHANNELS * SAMPLE_WIDTH + 2;
   localparam int AW = SAMPLE_WIDTH + 1;
   // Last table address; words past it are ignored so they cannot alias onto low entries
   localparam int TABLE_LAST = gamlut_pkg::TABLE_BASE_ADDR + ENTRIES - 1;

   typedef enum logic [1:0] {
      GAMLUT_IDLE = 2'b01,
      GAMLUT_RUN = 2'b10
   } gamlut_state_t;

   gamlut_state_t state_q, state_d;
   logic runEnable_q, runEnable_d;
   logic [SAMPLE_WIDTH-1:0] tableMem [CHANNELS][ENTRIES];
   logic [CHANNELS-1:0][SAMPLE_WIDTH-1:0] readData_q, readData_d;
   logic [CHANNELS-1:0] readValid_q, readValid_d;
   logic [CHANNELS*SAMPLE_WIDTH-1:0] corrected;
   gamlut_pkg::gamlut_beat_t fifoIn, fifoOut;
   logic fifoInReady, accept, running;
   logic midPacket_q, midPacket_d;

   // Port 0 control write
   // [R4] run enable write
   always_comb begin
      runEnable_d = runEnable_q;
      if (ctrlWrite[0] && ctrlAddress[0] == AW'(gamlut_pkg::RUN_CONTROL_ADDR)) begin
         runEnable_d = ctrlWriteData[0][gamlut_pkg::RUN_ENABLE_BIT];
      end
   end

   // Run state: stops only between packets, so a frame never ends mid-way
   always_comb begin
      state_d = state_q;
      case (state_q)
         GAMLUT_IDLE: begin
            if (runEnable_q) begin
               state_d = GAMLUT_RUN;
            end
         end
         GAMLUT_RUN: begin
            // [R4] stop at control read
            if (!runEnable_q && !(accept && !dinEndOfPacket) && !midPacket_q) begin
               state_d = GAMLUT_IDLE;
            end
         end
         default: state_d = GAMLUT_IDLE;
      endcase
   end

   // Packet tracking: the control read point is the start of a packet
   always_comb begin
      midPacket_d = midPacket_q;
      if (accept) begin
         midPacket_d = !dinEndOfPacket;
      end
   end

   assign running = (state_q == GAMLUT_RUN);
   // [R11] input ready under back-pressure and run state
   assign dinReady = fifoInReady && running && (runEnable_q || midPacket_q);
   assign accept = dinValid && dinReady;

   // Correction, combinational lookup of the live table
   // [R2] live table read
   // [R7] index x selects address x plus 2
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         corrected[c*SAMPLE_WIDTH +: SAMPLE_WIDTH] =
            tableMem[c][dinData[c*SAMPLE_WIDTH +: SAMPLE_WIDTH]];
      end
   end

   always_comb begin
      fifoIn.data = corrected;
      fifoIn.startOfPacket = dinStartOfPacket;
      fifoIn.endOfPacket = dinEndOfPacket;
   end

   // Register reads, one cycle latency; unmapped bits read zero
   // [R1] per-channel ports
   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         readValid_d[c] = ctrlRead[c];
         readData_d[c] = '0;
         if (ctrlRead[c]) begin
            if (ctrlAddress[c] >= AW'(gamlut_pkg::TABLE_BASE_ADDR)
               && ctrlAddress[c] <= AW'(TABLE_LAST)) begin
               // [R6] table window
               readData_d[c] = tableMem[c][SAMPLE_WIDTH'(ctrlAddress[c]
                  - AW'(gamlut_pkg::TABLE_BASE_ADDR))];
            end else if (c == 0 && ctrlAddress[c] == AW'(gamlut_pkg::RUN_CONTROL_ADDR)) begin
               readData_d[c][gamlut_pkg::RUN_ENABLE_BIT] = runEnable_q;
            end else if (c == 0 && ctrlAddress[c] == AW'(gamlut_pkg::RUN_STATE_ADDR)) begin
               // [R5] status bit
               // [R12] running reads one
               readData_d[c][gamlut_pkg::RUN_STATE_BIT] = running;
            end
            // [R8] ports 1 and 2 low addresses read zero
         end
      end
   end

   // Table storage, written from each channel's port
   // [R3] sample-width entries
   always_ff @(posedge clock) begin
      for (int c = 0; c < CHANNELS; c++) begin
         if (ctrlWrite[c] && ctrlAddress[c] >= AW'(gamlut_pkg::TABLE_BASE_ADDR)
            && ctrlAddress[c] <= AW'(TABLE_LAST)) begin
            // [R6] table write
            tableMem[c][SAMPLE_WIDTH'(ctrlAddress[c] - AW'(gamlut_pkg::TABLE_BASE_ADDR))]
               <= ctrlWriteData[c];
         end
      end
   end

   // Control state registers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_q <= GAMLUT_IDLE;
         runEnable_q <= gamlut_pkg::RUN_ENABLE_RESET;
         midPacket_q <= 1'b0;
         readData_q <= '0;
         readValid_q <= '0;
      end else begin
         state_q <= state_d;
         runEnable_q <= runEnable_d;
         midPacket_q <= midPacket_d;
         readData_q <= readData_d;
         readValid_q <= readValid_d;
      end
   end

   assign ctrlReadData = readData_q;
   assign ctrlReadDataValid = readValid_q;

   // Output buffer; its fullness stalls the input ready
   // [R10] downstream ready drains buffer
   gamlut_fifo #(
      .WIDTH(BW),
      .DEPTH(FIFO_DEPTH)
   ) outBuffer (
      .clock(clock),
      .reset_n(reset_n),
      .inValid(accept),
      .inReady(fifoInReady),
      .inData(fifoIn),
      .outValid(doutValid),
      .outReady(doutReady),
      .outData(fifoOut)
   );

   assign doutData = fifoOut.data;
   assign doutStartOfPacket = fifoOut.startOfPacket;
   assign doutEndOfPacket = fifoOut.endOfPacket;
endmodule
`default_nettype wire

// [rtl/gamlut_fifo.sv]
// Parameterised ready/valid FIFO for the corrected stream
`timescale 1ns/1ps
`default_nettype none
module gamlut_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
   logic [AW:0] count_q, count_d;
   logic [WIDTH-1:0] outData_q, outData_d;
   logic outValid_q, outValid_d;
   logic push, pop, load;

   // Storage holds DEPTH words; the output register adds one more
   assign inReady = (count_q != (AW+1)'(DEPTH));
   assign push = inValid && inReady;
   assign load = (count_q != '0) && (!outValid_q || outReady);
   assign pop = load;
   assign outValid = outValid_q;
   assign outData = outData_q;

   // Next pointer, count and output register
   always_comb begin
      wrPtr_d = push ? AW'(wrPtr_q + 1'b1) : wrPtr_q;
      rdPtr_d = pop ? AW'(rdPtr_q + 1'b1) : rdPtr_q;
      count_d = count_q;
      if (push && !pop) begin
         count_d = count_q + 1'b1;
      end else if (pop && !push) begin
         count_d = count_q - 1'b1;
      end
      outData_d = load ? mem[rdPtr_q] : outData_q;
      outValid_d = load ? 1'b1 : (outReady ? 1'b0 : outValid_q);
   end

   // Registers; memory written without reset to stay RAM-like
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
      if (!reset_n) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
         outData_q <= '0;
         outValid_q <= 1'b0;
      end else begin
         wrPtr_q <= wrPtr_d;
         rdPtr_q <= rdPtr_d;
         count_q <= count_d;
         outData_q <= outData_d;
         outValid_q <= outValid_d;
      end
   end
endmodule
`default_nettype wire

// [rtl/gamlut_pkg.sv]
// Package of constants and carrier types for the gamma look-up corrector
package gamlut_pkg;
   // Sample width and channel count defaults
   localparam int SAMPLE_WIDTH = 8;
   localparam int CHANNELS = 3;
   // Control port register offsets
   localparam int RUN_CONTROL_ADDR = 0;
   localparam int RUN_STATE_ADDR = 1;
   localparam int TABLE_BASE_ADDR = 2;
   // Field positions
   localparam int RUN_ENABLE_BIT = 0;
   localparam int RUN_STATE_BIT = 0;
   // Reset values
   localparam logic RUN_ENABLE_RESET = 1'b0;
   // Stream buffering
   localparam int FIFO_DEPTH = 32;
   // Stream word carrying every channel plus packet framing
   typedef struct packed {
      logic [CHANNELS*SAMPLE_WIDTH-1:0] data;
      logic startOfPacket;
      logic endOfPacket;
   } gamlut_beat_t;
   // Per-port register bus request
   typedef struct packed {
      logic read;
      logic write;
      logic [SAMPLE_WIDTH:0] address;
      logic [SAMPLE_WIDTH-1:0] writeData;
   } gamlut_req_t;
endpackage

// [testbench/gamlut_assertions.sv]
// Port checks for the gamma look-up corrector
`timescale 1ns/1ps
`default_nettype none
module gamlut_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Control ports
   input wire logic [2:0] ctrlRead,
   input wire logic [2:0] ctrlWrite,
   input wire logic [2:0][8:0] ctrlAddress,
   input wire logic [2:0][7:0] ctrlWriteData,
   input wire logic [2:0][7:0] ctrlReadData,
   input wire logic [2:0] ctrlReadDataValid,
   // Streams
   input wire logic dinReady,
   input wire logic doutValid,
   input wire logic doutReady,
   input wire logic [23:0] doutData
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Run enable set on port 0, and a status read with no write beside it
   sequence runOn;
      ctrlWrite[0] && ctrlAddress[0] == 9'h0 && ctrlWriteData[0][0];
   endsequence
   sequence askState;
      ctrlRead[0] && !ctrlWrite[0] && ctrlAddress[0] == 9'h1;
   endsequence
   a_read_answer: assert property (ctrlRead != 3'h0 |=> ctrlReadDataValid == $past(ctrlRead))
      else $error("read not answered");
   a_no_stray: assert property (ctrlReadDataValid != 3'h0 |-> $past(ctrlRead) == ctrlReadDataValid)
      else $error("stray read valid");
   a_spare_zero: assert property (ctrlRead[1] && ctrlAddress[1] < 9'h2 |=> ctrlReadData[1] == 8'h0)
      else $error("spare not zero");
   a_unused_bits: assert property (ctrlRead[0] && ctrlAddress[0] < 9'h2 |=> ctrlReadData[0][7:1] == 7'h0)
      else $error("unused bits set");
   a_run_state: assert property (runOn ##1 !ctrlWrite[0] ##1 askState |=> ctrlReadData[0][0])
      else $error("status not running");
   a_stopped_idle: assert property (!ctrlWrite[0] ##1 askState ##1 !ctrlReadData[0][0] |-> !dinReady)
      else $error("ready while stopped");
   a_reset_quiet: assert property ($rose(reset_n) |-> !dinReady && !doutValid)
      else $error("active after reset");
   a_dout_hold: assert property (doutValid && !doutReady |=> doutValid && $stable(doutData))
      else $error("output word dropped");
endmodule
bind gamlut_corrector gamlut_checker i_gamlut_checker (.clock, .reset_n, .ctrlRead, .ctrlWrite,
   .ctrlAddress, .ctrlWriteData, .ctrlReadData, .ctrlReadDataValid, .dinReady, .doutValid,
   .doutReady, .doutData);
`default_nettype wire

// [testbench/gamlut_corrector_tb.sv]
// Self-checking bench for the gamma look-up corrector
`timescale 1ns/1ps
`default_nettype none
module gamlut_corrector_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] ctrlRead = '0, ctrlWrite = '0, ctrlReadDataValid;
   logic [2:0][8:0] ctrlAddress = '0;
   logic [2:0][7:0] ctrlWriteData = '0, ctrlReadData;
   logic [1:0] slow = 2'h0;
   logic dinValid, dinReady, dinStartOfPacket, dinEndOfPacket, doutValid, doutReady;
   logic doutStartOfPacket, doutEndOfPacket;
   logic [23:0] dinData, doutData;
   int err_count = 0, tests_run = 0, cyc = 0;
   always #12.5 clock = ~clock;
   gamlut_corrector i_gamlut_corrector (.clock, .reset_n, .ctrlRead, .ctrlWrite, .ctrlAddress,
      .ctrlWriteData, .ctrlReadData, .ctrlReadDataValid, .dinValid, .dinReady, .dinData,
      .dinStartOfPacket, .dinEndOfPacket, .doutValid, .doutReady, .doutData,
      .doutStartOfPacket, .doutEndOfPacket);
   gamlut_peer i_gamlut_peer (.clock, .slow, .dinValid, .dinReady, .dinData,
      .dinStartOfPacket, .dinEndOfPacket, .doutValid, .doutReady, .doutData,
      .doutStartOfPacket, .doutEndOfPacket);
   // Table contents and corrected word the bench expects
   function automatic logic [7:0] tab(int c, int x);
      return 8'(x * 3 + c * 85 + 1);
   endfunction
   function automatic logic [23:0] fix(logic [23:0] d);
      return {tab(2, d[23:16]), tab(1, d[15:8]), tab(0, d[7:0])};
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Register cycles: strobe for one edge, read answer one cycle later
   task automatic wr(input int p, input int a, input logic [7:0] d);
      @(negedge clock);
      ctrlWrite[p] = 1'b1;
      ctrlAddress[p] = 9'(a);
      ctrlWriteData[p] = d;
      @(negedge clock);
      ctrlWrite[p] = 1'b0;
   endtask
   task automatic rd(input int p, input int a, input logic [7:0] exp);
      @(negedge clock);
      ctrlRead[p] = 1'b1;
      ctrlAddress[p] = 9'(a);
      @(negedge clock);
      ctrlRead[p] = 1'b0;
      chk({15'h0, ctrlReadDataValid[p], ctrlReadData[p]}, {16'h1, exp});
   endtask
   task automatic t_table;
      for (int c = 0; c < 3; c++)
         for (int x = 0; x < 256; x++) wr(c, x + 2, tab(c, x));
      rd(2, 257, tab(2, 255));
      rd(0, 2, tab(0, 0));
      $display("table done");
   endtask
   task automatic t_regs;
      rd(0, 1, 8'h00);
      for (int p = 1; p < 3; p++) begin
         wr(p, 0, 8'hff);
         rd(p, 0, 8'h00);
         rd(p, 1, 8'h00);
      end
      wr(0, 0, 8'hff);
      rd(0, 1, 8'h01);
      rd(0, 0, 8'h01);
      $display("regs done");
   endtask
   task automatic t_flood;
      int n;
      slow <= 2'h2;
      i_gamlut_peer.flood(40, 2'h3, n);
      chk(24'(n), 24'h21);
      chk({23'h0, doutValid}, 24'h1);
      slow <= 2'h1;
      for (int i = 0; i < 200 && i_gamlut_peer.got.size() < 33; i++) @(negedge clock);
      for (int i = 0; i < 33; i++) begin
         chk(i_gamlut_peer.got[i], fix({3{8'(i)}}));
         chk({22'h0, i_gamlut_peer.frm[i]}, 24'h3);
      end
      i_gamlut_peer.got.delete();
      i_gamlut_peer.frm.delete();
      $display("flood done");
   endtask
   task automatic t_live;
      int n;
      slow <= 2'h0;
      i_gamlut_peer.flood(1, 2'h3, n);
      wr(1, 2, 8'hc3);
      i_gamlut_peer.flood(1, 2'h3, n);
      repeat (6) @(negedge clock);
      chk(i_gamlut_peer.got[0], fix(24'h0));
      chk(i_gamlut_peer.got[1], {tab(2, 0), 8'hc3, tab(0, 0)});
      $display("live done");
   endtask
   // Stop requested inside a packet: the open packet still closes, then no more
   task automatic t_stop;
      int n;
      i_gamlut_peer.flood(1, 2'h2, n);
      chk(24'(n), 24'h1);
      wr(0, 0, 8'h00);
      rd(0, 1, 8'h01);
      i_gamlut_peer.flood(1, 2'h1, n);
      chk(24'(n), 24'h1);
      repeat (2) @(negedge clock);
      rd(0, 1, 8'h00);
      chk({23'h0, dinReady}, 24'h0);
      chk({22'h0, i_gamlut_peer.frm[2]}, 24'h2);
      chk({22'h0, i_gamlut_peer.frm[3]}, 24'h1);
      chk(i_gamlut_peer.got[3], {tab(2, 0), 8'hc3, tab(0, 0)});
      $display("stop done");
   endtask
   // Reset in mid-run returns run enable, status and both streams to idle
   task automatic t_reset;
      wr(0, 0, 8'h01);
      @(negedge clock);
      reset_n = 1'b0;
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      rd(0, 0, 8'h00);
      rd(0, 1, 8'h00);
      chk({22'h0, doutValid, dinReady}, 24'h0);
      $display("reset done");
   endtask
   task automatic summarize;
      $display("tests %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge clock) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      t_table();
      t_regs();
      t_flood();
      t_live();
      t_stop();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire

// [testbench/gamlut_peer.sv]
// Upstream source and downstream sink of the pixel stream
`timescale 1ns/1ps
`default_nettype none
module gamlut_peer (
   // Clock; sink pace 0 prompt, 1 every other cycle, 2 stalled
   input wire logic clock,
   input wire logic [1:0] slow,
   // Upstream source
   output logic dinValid,
   input wire logic dinReady,
   output logic [23:0] dinData,
   output logic dinStartOfPacket,
   output logic dinEndOfPacket,
   // Downstream sink
   input wire logic doutValid,
   output logic doutReady,
   input wire logic [23:0] doutData,
   input wire logic doutStartOfPacket,
   input wire logic doutEndOfPacket
);
   logic [23:0] got[$];
   logic [1:0] frm[$];
   logic ph;
   initial {dinValid, dinData, dinStartOfPacket, dinEndOfPacket, doutReady, ph} = '0;
   // Ready only when a word can be taken; taken words and framing logged
   always @(negedge clock) begin
      ph = ~ph;
      doutReady = slow == 2'h0 || (slow == 2'h1 && ph);
      if (doutValid && doutReady) begin
         got.push_back(doutData);
         frm.push_back({doutStartOfPacket, doutEndOfPacket});
      end
   end
   // Beats framed {start, end} by frame, offered for n cycles; k counts words taken
   task automatic flood(input int n, input logic [1:0] frame, output int k);
      logic r;
      k = 0;
      {dinValid, dinStartOfPacket, dinEndOfPacket} = {1'b1, frame};
      repeat (n) begin
         dinData = {3{8'(k)}};
         r = dinReady;
         @(negedge clock);
         k += int'(r);
      end
      // Idle bus shows the inverse, never stale data
      {dinValid, dinData} = {1'b0, ~dinData};
   endtask
endmodule
`default_nettype wire
